// File: cbt_bit_timing.sv
// Overview of operation
// - A quantum lasts the prescaler value in module clock periods.
// - Each bit is edge slot, propagation, first and second phase buffer.
// - The edge slot lasts one quantum; edges elsewhere carry a phase error.
// - Prescaler 1..64, pre span 1..16, post span 1..8, jump width 1..4 are supported.
// - Resync moves the sample point at most the jump width.
// - One byte holds both spans, the other jump width and prescaler.
// - All four fields are coded as value minus one.
// - Nominal bit length is pre span plus post span plus one quantum for the edge slot.
// - Segments, sample point and synchronisation advance once per quantum.
// - At the sample point the bus bit is taken and sync type chosen.
// - Next transmit bit is ready at the sample point, zero delay.
// - Shortening the second buffer by the jump width never disturbs bus timing; an edge within reach skips the transmit update.
// - Recessive-to-dominant edges in the received stream resynchronise the bit timing.
// - Bit rates from below 1 kbit/s up to 1 Mbit/s are supported.
// - Timing writes take effect only while unlock and init are both set.
//
// The register addresses and the AHB-Lite interface to the registers were chosen for this implementation.
module cbt_bit_timing
  import cbt_pkg::*;
(
  // Clock and reset.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Bus transceiver side.
  input  wire logic        can_rx,
  output logic             can_tx,
  // Sample point report.
  output logic             sample_pulse,
  output logic             sample_bit
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  cbt_cfg_s    cfg_reg;
  cbt_areq_s   areq_reg;
  cbt_seg_e    seg_reg;
  logic        init_reg;
  logic        txd_reg;
  logic        unlock_reg;
  logic        wr_pend_reg;
  logic        rd_pend_reg;
  logic        rx_meta_reg;
  logic        rx_sync_reg;
  logic        rx_prev_reg;
  logic        edge_pend_reg;
  logic        sync_done_reg;
  logic        idle_reg;
  logic [3:0]  idle_cnt_reg;
  logic [4:0]  q_reg;
  logic [4:0]  ext_reg;
  logic [4:0]  cut_reg;
  logic        tx_next_reg;
  logic [4:0]  bitq_reg;
  logic        clean_reg;
  logic        tq_tick;
  logic        accept;
  logic        fall;
  logic        edge_q;
  logic        resync;
  logic [4:0]  jump;
  logic [4:0]  pre_base;
  logic [4:0]  post_base;
  logic [4:0]  ext_next;
  logic [4:0]  post_err;
  logic [31:0] rd_mux;

  // ----------------------------------------------------------------
  // Register slave
  // ----------------------------------------------------------------

  // Address phase taken only when the bus is ready and a transfer is real.
  assign accept = hsel && hready && htrans[1];

  // Reads insert one wait state so they always see the last write's effect.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      areq_reg    <= '0;
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end
    else
    begin
      wr_pend_reg <= accept && hwrite;
      rd_pend_reg <= accept && !hwrite;
      hreadyout   <= !(accept && !hwrite);
      hresp       <= 1'b0;
      if (accept)
      begin
        areq_reg <= '{addr: haddr[11:0], write: hwrite};
      end
    end
  end

  // Control bits written by software.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      init_reg   <= CBT_INIT_RST;
      txd_reg    <= CBT_TXD_RST;
      unlock_reg <= CBT_UNLOCK_RST;
    end
    else if (wr_pend_reg && areq_reg.addr == CBT_CTRL_OFS)
    begin
      init_reg   <= hwdata[CBT_INIT_BIT];
      txd_reg    <= hwdata[CBT_TXD_BIT];
      unlock_reg <= hwdata[CBT_UNLOCK_BIT];
    end
  end

  // Timing word; locked unless software holds both unlock and init.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_reg <= CBT_TIMING_RST;
    end
    else if (wr_pend_reg && areq_reg.addr == CBT_TIMING_OFS && unlock_reg && init_reg)
    begin
      cfg_reg <= hwdata[15:0] & CBT_TIMING_MASK;
    end
  end

  // Read multiplexer; unmapped offsets read as zero.
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (areq_reg.addr)
      CBT_CTRL_OFS:
      begin
        rd_mux[CBT_INIT_BIT]   = init_reg;
        rd_mux[CBT_TXD_BIT]    = txd_reg;
        rd_mux[CBT_UNLOCK_BIT] = unlock_reg;
      end
      CBT_STAT_OFS:
      begin
        rd_mux[CBT_ST_IDLE_BIT]               = idle_reg;
        rd_mux[CBT_ST_SMP_BIT]                = sample_bit;
        rd_mux[CBT_ST_SEG_LSB +: 2]           = seg_reg;
        rd_mux[CBT_ST_Q_LSB +: 5]             = q_reg;
      end
      CBT_TIMING_OFS: rd_mux[15:0] = cfg_reg;
      default:        rd_mux       = 32'h0000_0000;
    endcase
  end

  // Read data is loaded in the wait cycle and held until the next read.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (rd_pend_reg)
    begin
      hrdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Quantum prescaler
  // ----------------------------------------------------------------
  cbt_quantum_div u_div (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .run       (!init_reg),
    .divide_m1 (cfg_reg.quantum_prescaler),
    .tq_tick   (tq_tick)
  );

  // ----------------------------------------------------------------
  // Receive edge capture
  // ----------------------------------------------------------------

  // Two-flop synchroniser; only the second stage feeds logic.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
      rx_prev_reg <= 1'b1;
    end
    else
    begin
      rx_meta_reg <= can_rx;
      rx_sync_reg <= rx_meta_reg;
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Recessive-to-dominant edges are held until the next quantum decides.
  assign fall   = rx_prev_reg && !rx_sync_reg;
  assign edge_q = edge_pend_reg || fall;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      edge_pend_reg <= 1'b0;
    end
    else
    begin
      edge_pend_reg <= !tq_tick && !init_reg && edge_q;
    end
  end

  // ----------------------------------------------------------------
  // Segment sequencer
  // ----------------------------------------------------------------

  // Coded fields expanded to functional quantum counts.
  assign jump      = cbt_len({2'b00, cfg_reg.jump_limit});
  assign pre_base  = cbt_len(cfg_reg.pre_span);
  assign post_base = cbt_len({1'b0, cfg_reg.post_span});
  // Only one resynchronisation between two sample points.
  assign resync    = edge_q && !sync_done_reg && !idle_reg;
  // Positive error: quanta since the edge slot, capped at the jump width.
  assign ext_next  = resync ? cbt_min5(q_reg + CBT_ONE_Q, jump) : ext_reg;
  // Negative error: quanta left before the next edge slot.
  assign post_err  = post_base - q_reg;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      seg_reg       <= CBT_SEG_EDGE;
      q_reg         <= 5'h00;
      ext_reg       <= 5'h00;
      cut_reg       <= 5'h00;
      sync_done_reg <= 1'b0;
      sample_pulse  <= 1'b0;
    end
    else if (init_reg)
    begin
      seg_reg       <= CBT_SEG_EDGE;
      q_reg         <= 5'h00;
      ext_reg       <= 5'h00;
      cut_reg       <= 5'h00;
      sync_done_reg <= 1'b0;
      sample_pulse  <= 1'b0;
    end
    else if (!tq_tick)
    begin
      sample_pulse <= 1'b0;
    end
    else if (edge_q && idle_reg)
    begin
      // Hard sync: the quantum holding the edge becomes the edge slot.
      seg_reg       <= CBT_SEG_PRE;
      q_reg         <= 5'h00;
      ext_reg       <= 5'h00;
      cut_reg       <= 5'h00;
      sync_done_reg <= 1'b1;
      sample_pulse  <= 1'b0;
    end
    else
    begin
      sample_pulse <= 1'b0;
      unique case (seg_reg)
        CBT_SEG_EDGE:
        begin
          // An edge here has no phase error and is ignored.
          seg_reg <= CBT_SEG_PRE;
          q_reg   <= 5'h00;
          ext_reg <= 5'h00;
          cut_reg <= 5'h00;
        end
        CBT_SEG_PRE:
        begin
          ext_reg <= ext_next;
          if (resync)
          begin
            sync_done_reg <= 1'b1;
          end
          if (q_reg + CBT_ONE_Q >= pre_base + ext_next)
          begin
            seg_reg       <= CBT_SEG_POST;
            q_reg         <= 5'h00;
            sample_pulse  <= 1'b1;
            sync_done_reg <= 1'b0;
          end
          else
          begin
            q_reg <= q_reg + CBT_ONE_Q;
          end
        end
        CBT_SEG_POST:
        begin
          if (resync && post_err <= jump)
          begin
            // Error within reach: this quantum becomes the next edge slot.
            seg_reg       <= CBT_SEG_PRE;
            q_reg         <= 5'h00;
            ext_reg       <= 5'h00;
            cut_reg       <= 5'h00;
            sync_done_reg <= 1'b1;
          end
          else if (q_reg + CBT_ONE_Q + (resync ? jump : cut_reg) >= post_base)
          begin
            seg_reg       <= CBT_SEG_EDGE;
            q_reg         <= 5'h00;
            sync_done_reg <= sync_done_reg || resync;
          end
          else
          begin
            q_reg         <= q_reg + CBT_ONE_Q;
            cut_reg       <= resync ? jump : cut_reg;
            sync_done_reg <= sync_done_reg || resync;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Sample point processing
  // ----------------------------------------------------------------

  // The bus bit is taken at the sample point; a dominant bit ends idle,
  // eleven recessive bits in a row make the next edge a hard sync.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      sample_bit   <= 1'b1;
      idle_cnt_reg <= 4'h0;
      idle_reg     <= 1'b0;
      tx_next_reg  <= 1'b1;
    end
    else if (init_reg)
    begin
      idle_cnt_reg <= 4'h0;
      idle_reg     <= 1'b0;
    end
    else if (tq_tick && seg_reg == CBT_SEG_PRE && !(edge_q && idle_reg)
             && q_reg + CBT_ONE_Q >= pre_base + ext_next)
    begin
      sample_bit  <= rx_sync_reg;
      tx_next_reg <= txd_reg;
      if (!rx_sync_reg)
      begin
        idle_cnt_reg <= 4'h0;
        idle_reg     <= 1'b0;
      end
      else if (idle_cnt_reg + 4'h1 >= CBT_IDLE_BITS)
      begin
        idle_cnt_reg <= CBT_IDLE_BITS;
        idle_reg     <= 1'b1;
      end
      else
      begin
        idle_cnt_reg <= idle_cnt_reg + 4'h1;
      end
    end
  end

  // The next bit goes out at the start of the bit; a second buffer cut by the jump width
  // only moves that start; one ended at an edge within reach skips it, leaving can_tx unchanged.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      can_tx <= 1'b1;
    end
    else if (init_reg)
    begin
      can_tx <= 1'b1;
    end
    else if (tq_tick && seg_reg == CBT_SEG_EDGE && CBT_PROC_DELAY == 5'h00)
    begin
      can_tx <= tx_next_reg;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------

  // Helper: quanta in the previous bit and whether it saw no edge outside its edge slot.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bitq_reg  <= 5'h00;
      clean_reg <= 1'b0;
    end
    else if (init_reg)
    begin
      bitq_reg  <= 5'h00;
      clean_reg <= 1'b0;
    end
    else if (tq_tick)
    begin
      bitq_reg  <= (seg_reg == CBT_SEG_EDGE) ? CBT_ONE_Q : bitq_reg + CBT_ONE_Q;
      clean_reg <= (seg_reg == CBT_SEG_EDGE) || (clean_reg && !edge_q);
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  sequence s_read_addr;
    accept && !hwrite;
  endsequence

  sequence s_read_done;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (s_read_addr |=> s_read_done)
    else $error("read did not complete after exactly one wait state");

  a_write_lock: assert property (
    (wr_pend_reg && areq_reg.addr == CBT_TIMING_OFS && !(unlock_reg && init_reg))
    |=> $stable(cfg_reg))
    else $error("timing word changed while locked");

  a_edge_one_q: assert property (
    (tq_tick && !init_reg && seg_reg == CBT_SEG_EDGE && !(edge_q && idle_reg))
    |=> seg_reg == CBT_SEG_PRE && q_reg == 5'h00)
    else $error("edge slot did not last exactly one quantum");

  a_sample_place: assert property (sample_pulse |->
    seg_reg == CBT_SEG_POST && $past(seg_reg) == CBT_SEG_PRE && $past(tq_tick))
    else $error("sample pulse outside the pre to post boundary");

  a_bit_length: assert property (
    (tq_tick && !init_reg && seg_reg == CBT_SEG_EDGE && clean_reg && bitq_reg != 5'h00)
    |-> bitq_reg == {1'b0, cfg_reg.pre_span} + {2'b00, cfg_reg.post_span} + CBT_SEG_FIXED)
    else $error("nominal bit length wrong");

  a_jump_bound: assert property (ext_reg <= jump && cut_reg <= jump)
    else $error("resync moved more than the jump width");

  a_sample_value: assert property (sample_pulse |-> sample_bit == $past(rx_sync_reg))
    else $error("sampled bit not taken at the sample point");

  a_tx_at_start: assert property (
    $changed(can_tx) |-> (init_reg || ($past(tq_tick) && $past(seg_reg) == CBT_SEG_EDGE)))
    else $error("transmit level changed away from a bit start");

  a_hard_sync: assert property (
    (tq_tick && !init_reg && edge_q && idle_reg) |=> seg_reg == CBT_SEG_PRE && q_reg == 5'h00)
    else $error("hard sync did not restart the bit");

endmodule // cbt_bit_timing

// File: cbt_pkg.sv
package cbt_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] CBT_CTRL_OFS    = 12'h000;
  localparam logic [11:0] CBT_STAT_OFS    = 12'h004;
  localparam logic [11:0] CBT_TIMING_OFS  = 12'h00C;
  localparam logic [15:0] CBT_TIMING_RST  = 16'h2301;
  localparam logic [15:0] CBT_TIMING_MASK = 16'h7FFF;

  // Control register bit positions and reset values.
  localparam int          CBT_INIT_BIT    = 0;
  localparam int          CBT_TXD_BIT     = 1;
  localparam int          CBT_UNLOCK_BIT  = 6;
  localparam logic        CBT_INIT_RST    = 1'b1;
  localparam logic        CBT_TXD_RST     = 1'b1;
  localparam logic        CBT_UNLOCK_RST  = 1'b0;

  // Status register field positions.
  localparam int          CBT_ST_IDLE_BIT = 0;
  localparam int          CBT_ST_SMP_BIT  = 1;
  localparam int          CBT_ST_SEG_LSB  = 2;
  localparam int          CBT_ST_Q_LSB    = 8;

  // ----------------------------------------------------------------
  // Timing constants
  // ----------------------------------------------------------------
  localparam logic [4:0]  CBT_SEG_FIXED   = 5'h03;
  localparam logic [4:0]  CBT_ONE_Q       = 5'h01;
  localparam logic [3:0]  CBT_IDLE_BITS   = 4'hB;
  localparam logic [4:0]  CBT_PROC_DELAY  = 5'h00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       rsvd;
    logic [2:0] post_span;
    logic [3:0] pre_span;
    logic [1:0] jump_limit;
    logic [5:0] quantum_prescaler;
  } cbt_cfg_s;

  typedef struct packed {
    logic [11:0] addr;
    logic        write;
  } cbt_areq_s;

  typedef enum logic [1:0] {CBT_SEG_EDGE, CBT_SEG_PRE, CBT_SEG_POST} cbt_seg_e;

  // Smaller of two quantum counts.
  function automatic logic [4:0] cbt_min5(input logic [4:0] a, input logic [4:0] b);
    cbt_min5 = (a < b) ? a : b;
  endfunction

  // Functional length of a minus-one coded field.
  function automatic logic [4:0] cbt_len(input logic [3:0] coded);
    cbt_len = {1'b0, coded} + CBT_ONE_Q;
  endfunction

endpackage

// File: cbt_quantum_div.sv
module cbt_quantum_div
  import cbt_pkg::*;
(
  // Clock and reset.
  input  wire logic       hclk,
  input  wire logic       hresetn,
  // Control.
  input  wire logic       run,
  input  wire logic [5:0] divide_m1,
  // Quantum strobe.
  output logic            tq_tick
);

  logic [5:0] count_reg;
  logic [5:0] gap_reg;
  logic       gap_ok_reg;

  // One strobe every divide_m1 + 1 module clocks; held at zero when stopped.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_reg <= 6'h00;
      tq_tick   <= 1'b0;
    end
    else if (!run)
    begin
      count_reg <= 6'h00;
      tq_tick   <= 1'b0;
    end
    else if (count_reg == divide_m1)
    begin
      count_reg <= 6'h00;
      tq_tick   <= 1'b1;
    end
    else
    begin
      count_reg <= count_reg + 6'h01;
      tq_tick   <= 1'b0;
    end
  end

  // Helper: cycles since the previous strobe, valid once a full gap is seen.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gap_reg    <= 6'h00;
      gap_ok_reg <= 1'b0;
    end
    else if (!run)
    begin
      gap_reg    <= 6'h00;
      gap_ok_reg <= 1'b0;
    end
    else if (tq_tick)
    begin
      gap_reg    <= 6'h00;
      gap_ok_reg <= 1'b1;
    end
    else
    begin
      gap_reg <= gap_reg + 6'h01;
    end
  end

  a_tick_period: assert property (@(posedge hclk) disable iff (!hresetn)
    (tq_tick && gap_ok_reg && run) |-> (gap_reg == divide_m1))
    else $error("quantum strobe spacing differs from prescaler");

endmodule // cbt_quantum_div

// File: cbt_bus_node.sv
module cbt_bus_node
(
  // Clock.
  input  wire logic hclk,
  // Bus levels.
  input  wire logic can_tx,
  output logic      can_rx
);
  timeunit 1ns;
  timeprecision 100ps;

  logic pull_low;

  // --------------------------------------------------------------
  // Wired-AND bus
  // --------------------------------------------------------------
  // A dominant zero from either node wins; released lines float high.
  assign can_rx = can_tx & ~pull_low;

  initial pull_low = 1'b0;

  // Holds a level for whole clocks, changing only just after an edge.
  task automatic drive(input logic level, input int clocks);
    pull_low <= ~level;
    repeat (clocks) @(posedge hclk);
  endtask
endmodule // cbt_bus_node

// File: can_bit_timing_logic_tb.sv
module can_bit_timing_logic_tb
  import cbt_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        can_rx;
  logic        can_tx;
  logic        sample_pulse;
  logic        sample_bit;
  int          num_errors;
  int          checked;
  int          cyc;
  int          pq[$];
  logic        bq[$];

  cbt_bit_timing dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .can_rx(can_rx),
    .can_tx(can_tx), .sample_pulse(sample_pulse), .sample_bit(sample_bit));

  cbt_bus_node node_u (.hclk(hclk), .can_tx(can_tx), .can_rx(can_rx));

  // --------------------------------------------------------------
  // Clock, sample point log and watchdog
  // --------------------------------------------------------------
  // The clock toggles every 2 ns, a period of 4 ns.
  initial hclk = 1'b0;
  always #2 hclk = ~hclk;

  // Sample points are logged with their cycle so spacing can be judged later.
  always @(posedge hclk)
  begin
    cyc <= cyc + 1;
    if (sample_pulse === 1'b1)
    begin
      pq.push_back(cyc);
      bq.push_back(sample_bit);
    end
  end

  // The whole run needs well under 10000 cycles, so 25000 means a hang.
  initial
  begin
    #100000;
    num_errors++;
    conclude();
  end

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checked++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One single AHB-Lite transfer; read data is taken at the edge ending the data phase.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    haddr  <= {20'h00000, a};
    hwrite <= w;
    hsize  <= 3'b010;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= wd;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
    check({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    xfer(1'b1, a, d, dummy);
  endtask

  task automatic rd_check(input logic [11:0] a, input logic [31:0] exp, input string msg);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    check(v, exp, msg);
  endtask

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_reset_values();
    rd_check(CBT_CTRL_OFS, (32'(CBT_INIT_RST) << CBT_INIT_BIT)
             | (32'(CBT_TXD_RST) << CBT_TXD_BIT), "control reset");
    rd_check(CBT_TIMING_OFS, {16'h0, CBT_TIMING_RST}, "timing reset");
    rd_check(12'h008, 32'h0, "unmapped read");
  endtask

  // Timing writes land only with unlock and init both set.
  task automatic t_write_lock();
    wr(CBT_TIMING_OFS, 32'h1234);
    rd_check(CBT_TIMING_OFS, {16'h0, CBT_TIMING_RST}, "locked, init only");
    wr(CBT_CTRL_OFS, 32'h42);
    wr(CBT_TIMING_OFS, 32'h1234);
    rd_check(CBT_TIMING_OFS, {16'h0, CBT_TIMING_RST}, "unlock without init");
    wr(CBT_CTRL_OFS, 32'h43);
    wr(CBT_TIMING_OFS, 32'h34C1);
    rd_check(CBT_TIMING_OFS, 32'h34C1, "timing word");
    wr(CBT_TIMING_OFS, 32'hFFFF_FFFF);
    rd_check(CBT_TIMING_OFS, 32'h7FFF, "upper bits");
  endtask

  // Bit length in clocks is prescaler times the quanta of both spans plus the one-quantum edge slot.
  task automatic t_bit_length();
    logic [15:0] words[3] = '{16'h0100, 16'h2582, 16'h7FDF};
    int          clocks[3] = '{4, 30, 800};
    for (int k = 0; k < 3; k++)
    begin
      wr(CBT_CTRL_OFS, 32'h43);
      wr(CBT_TIMING_OFS, {16'h0, words[k]});
      wr(CBT_CTRL_OFS, 32'h02);
      pq.delete();
      bq.delete();
      for (int i = 0; i < 3000 && pq.size() < 3; i++) @(posedge hclk);
      check(32'(pq.size()), 32'd3, "sample count");
      check(32'(pq[2] - pq[1]), 32'(clocks[k]), "bit length");
      check({31'h0, bq[2]}, 32'h1, "idle sample");
    end
    wr(CBT_CTRL_OFS, 32'h43);
    repeat (5) @(posedge hclk);
    pq.delete();
    repeat (100) @(posedge hclk);
    check(32'(pq.size()), 32'd0, "stopped under init");
    rd_check(CBT_STAT_OFS, 32'h2, "status under init");
  endtask

  // Hard sync on an idle bus, a plain bit, then a late edge that resyncs.
  task automatic t_sync();
    int c0;
    int gap;
    wr(CBT_TIMING_OFS, {16'h0, CBT_TIMING_RST});
    wr(CBT_CTRL_OFS, 32'h02);
    repeat (300) @(posedge hclk);
    pq.delete();
    bq.delete();
    c0 = cyc;
    node_u.drive(1'b0, 16);
    node_u.drive(1'b1, 22);
    node_u.drive(1'b0, 16);
    node_u.drive(1'b1, 40);
    while (pq.size() > 0 && pq[0] < c0 + 5)
    begin
      void'(pq.pop_front());
      void'(bq.pop_front());
    end
    check(32'(pq.size() >= 3), 32'h1, "sync samples");
    gap = pq[0] - c0;
    check(32'(gap >= 10 && gap <= 18), 32'h1, "hard sync placement");
    check(32'(pq[1] - pq[0]), 32'd16, "nominal bit");
    gap = pq[2] - pq[1];
    check(32'(gap > 16 && gap <= 18), 32'h1, "late edge lengthens");
    check({29'h0, bq[0], bq[1], bq[2]}, 32'h2, "sampled levels");
  endtask

  // The transmit level follows the control bit from the bit start after the next sample point.
  task automatic t_transmit();
    wr(CBT_CTRL_OFS, 32'h00);
    repeat (64) @(posedge hclk);
    check({31'h0, can_tx}, 32'h0, "dominant transmit");
    check({31'h0, sample_bit}, 32'h0, "own bit read back");
    wr(CBT_CTRL_OFS, 32'h02);
    repeat (64) @(posedge hclk);
    check({31'h0, can_tx}, 32'h1, "recessive transmit");
  endtask

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    haddr   = 32'h0;
    htrans  = 2'b00;
    hwrite  = 1'b0;
    hsize   = 3'b010;
    hwdata  = 32'h0;
    cyc     = 0;
    repeat (20) @(posedge hclk);
    check({30'h0, can_tx, sample_bit}, 32'h3, "levels in reset");
    check({30'h0, hreadyout, hresp}, 32'h2, "bus in reset");
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset_values();
    t_write_lock();
    t_bit_length();
    t_sync();
    t_transmit();
    conclude();
  end
endmodule // can_bit_timing_logic_tb
